// *** hw/pnr_pkg.sv ***
// pnr_pkg: offsets, reset values and carriers of the configuration register bank
package pnr_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_SET_READ_PORT = 8'h00;
	localparam logic [7:0] IDX_CONFIG_CONTROL = 8'h02;
	localparam logic [7:0] IDX_WAKE_CARD = 8'h03;
	localparam logic [7:0] IDX_CARD_SELECT_NUMBER = 8'h06;
	localparam logic [7:0] IDX_LOGICAL_DEVICE_SELECT = 8'h07;
	localparam logic [7:0] IDX_CHIP_IDENTITY = 8'h20;
	localparam logic [7:0] IDX_CHIP_CONFIG_ONE = 8'h21;
	localparam logic [7:0] IDX_CHIP_CONFIG_TWO = 8'h22;
	localparam logic [7:0] IDX_CHIP_SELECT_CFG_INDEX = 8'h23;
	localparam logic [7:0] IDX_CHIP_SELECT_CFG_DATA = 8'h24;
	localparam logic [7:0] IDX_CHIP_REVISION = 8'h27;
	localparam logic [7:0] IDX_ACTIVATE = 8'h30;
	localparam logic [7:0] IDX_RANGE_CHECK = 8'h31;
	localparam logic [7:0] IDX_DATA_BASE_HIGH = 8'h60;
	localparam logic [7:0] IDX_DATA_BASE_LOW = 8'h61;
	localparam logic [7:0] IDX_CMD_BASE_HIGH = 8'h62;
	localparam logic [7:0] IDX_CMD_BASE_LOW = 8'h63;
	localparam logic [7:0] IDX_IRQ_SELECT = 8'h70;
	localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
	localparam logic [7:0] IDX_DMA_A = 8'h74;
	localparam logic [7:0] IDX_DMA_B = 8'h75;
	localparam logic [7:0] IDX_VENDOR_CONFIG = 8'hf0;
	// own register: function-enable bits, bit 0 gates the keyboard
	localparam logic [7:0] IDX_FUNCTION_ENABLE = 8'hf8;

	// ----------------------------------------------------------------
	// reset values and fixed fields
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_DATA_BASE_LOW = 8'h60;
	localparam logic [7:0] RST_CMD_BASE_LOW = 8'h64;
	localparam logic [7:0] RST_KBD_IRQ_SELECT = 8'h01;
	localparam logic [1:0] RST_KBD_IRQ_TYPE = 2'h2;
	localparam logic [7:0] RST_FUNCTION_ENABLE = 8'h01;
	localparam logic [7:0] RST_VENDOR_CONFIG = 8'h00;
	localparam logic [7:0] RST_CHIP_CONFIG = 8'h00;
	localparam logic [1:0] STRONG_PULL_CYCLES = 2'h3;
	localparam logic [7:0] DMA_NONE_BYTE = 8'h04;
	localparam logic [2:0] DMA_NONE = 3'h4;
	localparam logic [3:0] IRQ_NONE = 4'h0;
	localparam int BASE_FIXED_BIT = 2;
	localparam int SOFT_RESET_BIT = 0;
	localparam logic [7:0] KBD_DEVICE = 8'h00;
	// arbitrary neutral identity values
	localparam logic [7:0] CHIP_IDENTITY_VALUE = 8'h5a;
	localparam logic [7:0] CHIP_REVISION_VALUE = 8'h01;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] irq_line_o;
		logic [15:0] irq_line_oe;
		logic [7:0] dma_req;
		logic active;
	} pnr_host_side_t;

endpackage

// *** hw/pnr_config_regs.sv ***
// pnr_config_regs: configuration register bank with keyboard resource routing
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module pnr_config_regs
	import pnr_pkg::*;
(
	input wire logic sys_clk, // chip clock, 10 MHz
	input wire logic reset_n, // hard reset, async active low
	input wire logic [7:0] avs_address, // word index
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data, low byte used
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data, registered
	output logic avs_waitrequest, // stall until answer
	input wire logic strap_config_bit_zero, // activate reset strap
	input wire logic keyboard_irq_pin, // keyboard controller request, active high
	output logic [15:0] interrupt_request_line_o, // host irq line values
	output logic [15:0] interrupt_request_line_oe, // high while driving
	output logic [15:0] interrupt_request_line_weak, // weak pull-up enable
	output logic kbd_enabled // keyboard active on host bus
);
	import pnr_pkg::*;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic ack_q;
	logic [7:0] card_select_number_q, logical_device_select_q;
	logic [7:0] chip_config_one_q, chip_config_two_q;
	logic [7:0] chip_select_cfg_index_q, chip_select_cfg_data_q;
	logic kbd_activate_q;
	logic [1:0] kbd_range_check_q;
	logic [7:0] kbd_data_base_high_q, kbd_data_base_low_q;
	logic [7:0] kbd_cmd_base_high_q, kbd_cmd_base_low_q;
	logic [3:0] kbd_irq_select_q;
	logic [1:0] kbd_irq_type_q;
	logic [7:0] kbd_vendor_config_q, function_enable_reg_one_q;
	logic strap_q, strap_seen_q;
	logic [1:0] pull_cnt_q;
	logic kbd_irq_prev_q;
	logic [7:0] rd_byte;

	wire logic req = avs_read | avs_write;
	// one wait cycle, answer on the second edge of the request
	assign avs_waitrequest = req & ~ack_q;
	wire logic wr_fire = avs_write & ack_q & avs_byteenable[0];
	wire logic [7:0] wb = avs_writedata[7:0];
	// device registers reached only for the selected device
	wire logic kbd_sel = (logical_device_select_q == KBD_DEVICE);
	function automatic logic hit(input logic [7:0] idx);
		return wr_fire && avs_address == idx;
	endfunction
	wire logic dev_wr = wr_fire & kbd_sel;
	// soft reset pulse from control bit 0
	wire logic soft_rst = hit(IDX_CONFIG_CONTROL) & wb[SOFT_RESET_BIT];

	// ----------------------------------------------------------------
	// card level registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_q <= 1'b0;
			// hard reset clears card select number
			card_select_number_q <= RST_ZERO;
			logical_device_select_q <= RST_ZERO;
			chip_config_one_q <= RST_CHIP_CONFIG;
			chip_config_two_q <= RST_CHIP_CONFIG;
			chip_select_cfg_index_q <= RST_ZERO;
			chip_select_cfg_data_q <= RST_ZERO;
		end else begin
			ack_q <= req & ~ack_q;
			if (soft_rst) begin
				card_select_number_q <= RST_ZERO;
				logical_device_select_q <= RST_ZERO;
			end else begin
				if (hit(IDX_CARD_SELECT_NUMBER))
					card_select_number_q <= wb;
				if (hit(IDX_LOGICAL_DEVICE_SELECT))
					logical_device_select_q <= wb;
			end
			if (hit(IDX_CHIP_CONFIG_ONE))
				chip_config_one_q <= wb;
			if (hit(IDX_CHIP_CONFIG_TWO))
				chip_config_two_q <= wb;
			if (hit(IDX_CHIP_SELECT_CFG_INDEX))
				chip_select_cfg_index_q <= wb;
			if (hit(IDX_CHIP_SELECT_CFG_DATA))
				chip_select_cfg_data_q <= wb;
		end
	end

	// ----------------------------------------------------------------
	// keyboard device registers
	// ----------------------------------------------------------------
	// strap caught after release: async reset may only load constants
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_q <= 1'b0;
			strap_seen_q <= 1'b0;
		end else if (!strap_seen_q) begin
			strap_q <= strap_config_bit_zero;
			strap_seen_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			kbd_activate_q <= 1'b0;
			kbd_range_check_q <= 2'h0;
			kbd_data_base_high_q <= RST_ZERO;
			kbd_data_base_low_q <= RST_DATA_BASE_LOW;
			kbd_cmd_base_high_q <= RST_ZERO;
			kbd_cmd_base_low_q <= RST_CMD_BASE_LOW;
			kbd_irq_select_q <= RST_KBD_IRQ_SELECT[3:0];
			kbd_irq_type_q <= RST_KBD_IRQ_TYPE;
			kbd_vendor_config_q <= RST_VENDOR_CONFIG;
			function_enable_reg_one_q <= RST_FUNCTION_ENABLE;
		end else if (!strap_seen_q || soft_rst) begin
			// activate from strap on both reset kinds
			kbd_activate_q <= (strap_seen_q) ? strap_q : strap_config_bit_zero;
			kbd_range_check_q <= 2'h0;
			kbd_data_base_high_q <= RST_ZERO;
			kbd_data_base_low_q <= RST_DATA_BASE_LOW;
			kbd_cmd_base_high_q <= RST_ZERO;
			kbd_cmd_base_low_q <= RST_CMD_BASE_LOW;
			kbd_irq_select_q <= RST_KBD_IRQ_SELECT[3:0];
			kbd_irq_type_q <= RST_KBD_IRQ_TYPE;
			// vendor config untouched by soft reset
		end else begin
			if (dev_wr && avs_address == IDX_ACTIVATE)
				kbd_activate_q <= wb[0];
			if (dev_wr && avs_address == IDX_RANGE_CHECK)
				kbd_range_check_q <= wb[1:0];
			if (dev_wr && avs_address == IDX_DATA_BASE_HIGH)
				kbd_data_base_high_q <= wb;
			if (dev_wr && avs_address == IDX_DATA_BASE_LOW)
				kbd_data_base_low_q <= {wb[7:3], 1'b0, wb[1:0]};
			if (dev_wr && avs_address == IDX_CMD_BASE_HIGH)
				kbd_cmd_base_high_q <= wb;
			if (dev_wr && avs_address == IDX_CMD_BASE_LOW)
				kbd_cmd_base_low_q <= {wb[7:3], 1'b1, wb[1:0]};
			// low nibble holds the line number
			if (dev_wr && avs_address == IDX_IRQ_SELECT)
				kbd_irq_select_q <= wb[3:0];
			if (dev_wr && avs_address == IDX_IRQ_TYPE)
				kbd_irq_type_q <= wb[1:0];
			if (dev_wr && avs_address == IDX_VENDOR_CONFIG)
				kbd_vendor_config_q <= wb;
			if (hit(IDX_FUNCTION_ENABLE))
				function_enable_reg_one_q <= wb;
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	// fixed bits read back their constants
	always_comb begin
		rd_byte = RST_ZERO;
		unique case (avs_address)
			IDX_CARD_SELECT_NUMBER: rd_byte = card_select_number_q;
			IDX_LOGICAL_DEVICE_SELECT: rd_byte = logical_device_select_q;
			IDX_CHIP_IDENTITY: rd_byte = CHIP_IDENTITY_VALUE;
			IDX_CHIP_CONFIG_ONE: rd_byte = chip_config_one_q;
			IDX_CHIP_CONFIG_TWO: rd_byte = chip_config_two_q;
			IDX_CHIP_SELECT_CFG_INDEX: rd_byte = chip_select_cfg_index_q;
			IDX_CHIP_SELECT_CFG_DATA: rd_byte = chip_select_cfg_data_q;
			IDX_CHIP_REVISION: rd_byte = CHIP_REVISION_VALUE;
			IDX_FUNCTION_ENABLE: rd_byte = function_enable_reg_one_q;
			default: rd_byte = RST_ZERO;
		endcase
		if (kbd_sel) begin
			unique case (avs_address)
				IDX_ACTIVATE: rd_byte = {7'h00, kbd_activate_q};
				IDX_RANGE_CHECK: rd_byte = {6'h00, kbd_range_check_q};
				IDX_DATA_BASE_HIGH: rd_byte = kbd_data_base_high_q;
				IDX_DATA_BASE_LOW: rd_byte = kbd_data_base_low_q;
				IDX_CMD_BASE_HIGH: rd_byte = kbd_cmd_base_high_q;
				IDX_CMD_BASE_LOW: rd_byte = kbd_cmd_base_low_q;
				IDX_IRQ_SELECT: rd_byte = {4'h0, kbd_irq_select_q};
				IDX_IRQ_TYPE: rd_byte = {6'h00, kbd_irq_type_q};
				IDX_DMA_A: rd_byte = {5'h00, DMA_NONE};
				// second slot reports the same way
				IDX_DMA_B: rd_byte = DMA_NONE_BYTE;
				IDX_VENDOR_CONFIG: rd_byte = kbd_vendor_config_q;
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && !ack_q)
			avs_readdata <= {24'h00_0000, rd_byte};
	end

	// ----------------------------------------------------------------
	// interrupt routing
	// ----------------------------------------------------------------
	// effective enable needs activate and function enable
	assign kbd_enabled = kbd_activate_q & function_enable_reg_one_q[0];
	wire logic irq_used = kbd_enabled && kbd_irq_select_q != IRQ_NONE;
	wire logic high_pol = kbd_irq_type_q[1];
	// edge mode sends a one-cycle pulse per rising request
	wire logic req_edge = keyboard_irq_pin & ~kbd_irq_prev_q;
	wire logic irq_act = kbd_irq_type_q[0] ? keyboard_irq_pin : req_edge;
	wire logic pin_level = high_pol ? irq_act : ~irq_act;
	// keyboard dma slots are fixed at channel 4, so no dma request output exists

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			kbd_irq_prev_q <= 1'b0;
			pull_cnt_q <= 2'h0;
		end else begin
			kbd_irq_prev_q <= keyboard_irq_pin;
			// strong pull-up for a short burst after release of low
			if (irq_act)
				pull_cnt_q <= STRONG_PULL_CYCLES;
			else if (pull_cnt_q != 2'h0)
				pull_cnt_q <= pull_cnt_q - 2'h1;
		end
	end

	// one-hot line from the selected number
	wire logic [15:0] line_hot = 16'h0001 << kbd_irq_select_q;
	wire logic [15:0] line_mask = irq_used ? line_hot : 16'h0000;
	// push-pull when high, open drain when low
	wire logic drive_now = high_pol | irq_act | (pull_cnt_q != 2'h0);
	assign interrupt_request_line_o = line_mask & {16{pin_level}};
	assign interrupt_request_line_oe = line_mask & {16{drive_now}};
	assign interrupt_request_line_weak = line_mask & {16{~high_pol}};

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_wait_one;
		@(posedge sys_clk) disable iff (!reset_n)
		$rose(req) |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("answer not after one wait");

	property p_no_line_zero;
		@(posedge sys_clk) disable iff (!reset_n)
		kbd_irq_select_q == IRQ_NONE |-> interrupt_request_line_oe == 16'h0000;
	endproperty
	a_no_line_zero: assert property (p_no_line_zero) else $error("line zero driven");

	property p_line_pick;
		@(posedge sys_clk) disable iff (!reset_n)
		irq_used && high_pol |-> interrupt_request_line_oe == line_hot;
	endproperty
	a_line_pick: assert property (p_line_pick) else $error("wrong line driven");

	property p_soft_csn;
		@(posedge sys_clk) disable iff (!reset_n)
		soft_rst |=> card_select_number_q == RST_ZERO;
	endproperty
	a_soft_csn: assert property (p_soft_csn) else $error("csn not cleared");

	property p_soft_keep;
		@(posedge sys_clk) disable iff (!reset_n)
		soft_rst |=> $stable(chip_select_cfg_data_q) && $stable(kbd_vendor_config_q);
	endproperty
	a_soft_keep: assert property (p_soft_keep) else $error("chip reg lost on soft reset");

	property p_base_bits;
		@(posedge sys_clk) disable iff (!reset_n)
		!kbd_data_base_low_q[BASE_FIXED_BIT] && kbd_cmd_base_low_q[BASE_FIXED_BIT];
	endproperty
	a_base_bits: assert property (p_base_bits) else $error("fixed base bit wrong");

	sequence s_soft_irq;
		soft_rst ##1 kbd_irq_select_q == RST_KBD_IRQ_SELECT[3:0];
	endsequence
	property p_soft_irq;
		@(posedge sys_clk) disable iff (!reset_n)
		soft_rst |-> s_soft_irq;
	endproperty
	a_soft_irq: assert property (p_soft_irq) else $error("irq select not reset");

	property p_edge_pulse;
		@(posedge sys_clk) disable iff (!reset_n)
		irq_used && high_pol && !kbd_irq_type_q[0] && $rose(interrupt_request_line_o != 0)
			|=> interrupt_request_line_o == 16'h0000;
	endproperty
	a_edge_pulse: assert property (p_edge_pulse) else $error("edge pulse too long");

	property p_enable_gate;
		@(posedge sys_clk) disable iff (!reset_n)
		!function_enable_reg_one_q[0] |-> !kbd_enabled;
	endproperty
	a_enable_gate: assert property (p_enable_gate) else $error("enable not gated");

	property p_strong_pull;
		@(posedge sys_clk) disable iff (!reset_n)
		irq_used && !high_pol && $fell(irq_act)
			|-> interrupt_request_line_oe == line_hot && interrupt_request_line_o == line_hot;
	endproperty
	a_strong_pull: assert property (p_strong_pull) else $error("no strong pull-up");

	property p_push_pull;
		@(posedge sys_clk) disable iff (!reset_n)
		irq_used && high_pol |-> interrupt_request_line_o == (line_hot & {16{irq_act}});
	endproperty
	a_push_pull: assert property (p_push_pull) else $error("push-pull value wrong");

	property p_dma_report;
		@(posedge sys_clk) disable iff (!reset_n)
		avs_read && !ack_q && kbd_sel && (avs_address == IDX_DMA_A || avs_address == IDX_DMA_B)
			|=> avs_readdata[7:0] == DMA_NONE_BYTE;
	endproperty
	a_dma_report: assert property (p_dma_report) else $error("dma slot not free");

	property p_activate_bits;
		@(posedge sys_clk) disable iff (!reset_n)
		avs_read && !ack_q && kbd_sel && avs_address == IDX_ACTIVATE
			|=> avs_readdata[7:1] == 7'h00 && avs_readdata[0] == kbd_activate_q;
	endproperty
	a_activate_bits: assert property (p_activate_bits) else $error("activate read wrong");

endmodule
`default_nettype wire

// *** dv/pnr_irq_host_model.sv ***
// pnr_irq_host_model: host-side view of the interrupt request lines
`timescale 1ns/10ps
`default_nettype none
module pnr_irq_host_model (
	input wire logic sys_clk, // chip clock
	input wire logic [15:0] line_value, // value driven per line
	input wire logic [15:0] line_drive, // drive enable per line
	input wire logic [15:0] line_pull, // weak pull-up enable per line
	output logic [15:0] line_level // level seen by the host
);
	// a floating line wanders so a stale value is never mistaken for a pull-up
	logic [15:0] float_q = 16'h5555;
	always_ff @(posedge sys_clk) begin
		float_q <= ~float_q;
	end
	assign line_level = (line_drive & line_value) | (~line_drive & line_pull)
		| (~line_drive & ~line_pull & float_q);
endmodule
`default_nettype wire

// *** dv/pnr_config_regs_tb_top.sv ***
// pnr_config_regs_tb_top: self-checking bench for the configuration register bank
`timescale 1ns/10ps
`default_nettype none
module pnr_config_regs_tb_top;
	import pnr_pkg::*;
	// ----------------------------------------------------------------
	// signals and design
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] idx;
		logic [7:0] rst;
		logic [7:0] wd;
		logic [7:0] rb;
	} pnr_row_t;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic strap_config_bit_zero = 1'b1;
	logic keyboard_irq_pin = 1'b0;
	logic [15:0] irq_value;
	logic [15:0] irq_drive;
	logic [15:0] irq_pull;
	logic [15:0] irq_level;
	logic kbd_enabled;
	int n_fail = 0;
	int n_checks = 0;
	int cnt;
	logic [7:0] q;
	logic [15:0] e16;
	pnr_row_t rows [18] = '{
		'{8'h06, 8'h00, 8'h3c, 8'h3c}, '{8'h07, 8'h00, 8'h00, 8'h00},
		'{8'h30, 8'h01, 8'hff, 8'h01}, '{8'h31, 8'h00, 8'h03, 8'h03},
		'{8'h60, 8'h00, 8'h12, 8'h12}, '{8'h61, 8'h60, 8'hff, 8'hfb},
		'{8'h62, 8'h00, 8'h34, 8'h34}, '{8'h63, 8'h64, 8'h00, 8'h04},
		'{8'h70, 8'h01, 8'h0f, 8'h0f}, '{8'h71, 8'h02, 8'hff, 8'h03},
		'{8'h74, 8'h04, 8'h01, 8'h04}, '{8'h75, 8'h04, 8'h07, 8'h04},
		'{8'h23, 8'h00, 8'ha5, 8'ha5}, '{8'h24, 8'h00, 8'h5a, 8'h5a},
		'{8'hf0, 8'h00, 8'h77, 8'h77}, '{8'hf8, 8'h01, 8'h01, 8'h01},
		'{8'h20, CHIP_IDENTITY_VALUE, 8'h00, CHIP_IDENTITY_VALUE}, '{8'h0c, 8'h00, 8'hff, 8'h00}};
	logic [7:0] keep_idx [10] = '{8'h06, 8'h07, 8'h30, 8'h61, 8'h63, 8'h70, 8'h71,
		8'h23, 8'h24, 8'hf0};
	logic [7:0] keep_val [10] = '{8'h00, 8'h00, 8'h01, 8'h60, 8'h64, 8'h01, 8'h02,
		8'ha5, 8'h5a, 8'h77};

	always #50 sys_clk = ~sys_clk;

	pnr_config_regs i_pnr_config_regs (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(4'h1),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.strap_config_bit_zero(strap_config_bit_zero),
		.keyboard_irq_pin(keyboard_irq_pin),
		.interrupt_request_line_o(irq_value),
		.interrupt_request_line_oe(irq_drive),
		.interrupt_request_line_weak(irq_pull),
		.kbd_enabled(kbd_enabled)
	);
	pnr_irq_host_model i_pnr_irq_host_model (
		.sys_clk(sys_clk),
		.line_value(irq_value),
		.line_drive(irq_drive),
		.line_pull(irq_pull),
		.line_level(irq_level)
	);
	// ----------------------------------------------------------------
	// bus and check tasks
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// request held until waitrequest is sampled low at a rising edge, released right after it
	task automatic bus(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_read <= ~is_wr;
		avs_write <= is_wr;
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		if (avs_waitrequest !== 1'b0) begin
			n_fail++;
			conclude();
		end
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk("register read", {8'h00, q}, {8'h00, e});
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic pin(input logic v);
		@(posedge sys_clk);
		keyboard_irq_pin <= v;
	endtask
	task automatic hard_reset(input logic strap);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		strap_config_bit_zero <= strap;
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		hard_reset(1'b1);
		foreach (rows[i]) begin
			rd(rows[i].idx, rows[i].rst);
			wr(rows[i].idx, rows[i].wd);
			rd(rows[i].idx, rows[i].rb);
		end
		$display("test table done");
		wr(IDX_CONFIG_CONTROL, 8'h01);
		foreach (keep_idx[i]) begin
			rd(keep_idx[i], keep_val[i]);
		end
		$display("test soft reset done");
		wr(IDX_LOGICAL_DEVICE_SELECT, 8'h01);
		rd(IDX_IRQ_SELECT, 8'h00);
		wr(IDX_IRQ_SELECT, 8'h05);
		wr(IDX_LOGICAL_DEVICE_SELECT, 8'h00);
		rd(IDX_IRQ_SELECT, 8'h01);
		$display("test device select done");
		wr(IDX_IRQ_TYPE, 8'h03);
		pin(1'b1);
		for (int l = 0; l < 16; l++) begin
			wr(IDX_IRQ_SELECT, l[7:0]);
			settle(2);
			e16 = (l == 0) ? 16'h0000 : (16'h0001 << l);
			chk("line drive", irq_drive, e16);
			chk("line value", irq_value, e16);
		end
		wr(IDX_IRQ_SELECT, 8'h05);
		pin(1'b0);
		settle(3);
		chk("low driven", irq_drive, 16'h0020);
		chk("low value", irq_value, 16'h0000);
		wr(IDX_IRQ_TYPE, 8'h01);
		pin(1'b1);
		settle(3);
		chk("active low drive", irq_drive, 16'h0020);
		chk("active low level", {15'h0000, irq_level[5]}, 16'h0000);
		pin(1'b0);
		settle(1);
		chk("strong pull", {15'h0000, irq_drive[5]}, 16'h0001);
		settle(6);
		chk("released", irq_drive, 16'h0000);
		chk("weak pull", irq_pull, 16'h0020);
		chk("pulled level", {15'h0000, irq_level[5]}, 16'h0001);
		wr(IDX_IRQ_TYPE, 8'h02);
		cnt = 0;
		pin(1'b1);
		repeat (8) begin
			@(negedge sys_clk);
			cnt += int'(irq_value[5] === 1'b1);
		end
		chk("edge pulses", cnt[15:0], 16'h0001);
		$display("test interrupt routing done");
		chk("enabled", {15'h0000, kbd_enabled}, 16'h0001);
		wr(IDX_FUNCTION_ENABLE, 8'h00);
		settle(1);
		chk("gated", {15'h0000, kbd_enabled}, 16'h0000);
		wr(IDX_FUNCTION_ENABLE, 8'h01);
		wr(IDX_ACTIVATE, 8'h00);
		settle(1);
		chk("inactive", {15'h0000, kbd_enabled}, 16'h0000);
		pin(1'b0);
		hard_reset(1'b0);
		rd(IDX_ACTIVATE, 8'h00);
		rd(IDX_CARD_SELECT_NUMBER, 8'h00);
		chk("strap low", {15'h0000, kbd_enabled}, 16'h0000);
		$display("test enable and strap done");
		conclude();
	end
endmodule
`default_nettype wire
